// >>> verilog/l1c_pkg.sv
// Shared constants, register map and state encoding for the level-one cache.
package l1c_pkg;
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_INVAL = 12'h008;
	localparam int CTRL_TWO_WAY = 0;
	localparam int CTRL_REFILL4 = 1;
	localparam int CTRL_PART_LO = 2;
	localparam logic CTRL_TWO_WAY_RESET = 1'h0;
	localparam logic CTRL_REFILL4_RESET = 1'h0;
	localparam logic [1:0] CTRL_PART_RESET = 2'h0;
	localparam int STAT_BUSY = 0;
	localparam int STAT_LOCK_IGN = 1;
	localparam int INVAL_WAY_BIT = 16;
	localparam logic [31:0] PSW_DATA_LOCK_MASK = 32'h0010_0000;
	localparam logic [31:0] PSW_INSTR_LOCK_MASK = 32'h0008_0000;
	localparam int PART_VADDR_LO = 28;
	localparam logic [1:0] PART_NONE = 2'h0;
	localparam logic [1:0] PART_TWO = 2'h1;
	localparam logic [1:0] PART_FOUR = 2'h2;
	localparam logic [1:0] BURST_LAST_BEAT = 2'h3;
	localparam int DEF_LINES = 256;
	localparam int DEF_LINE_WORDS = 1;
	localparam int INSTR_LINE_WORDS = 4;
	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_LOOKUP,
		ST_MERGE,
		ST_MEMWR,
		ST_MEMRD
	} l1c_state_t;
endpackage

// >>> verilog/l1c_way_if.sv
// Connection between the cache controller and one way of tag and data storage.
`timescale 1ns/1ps
interface l1c_way_if #(parameter int IDX_W = 8, parameter int TAG_W = 30);
	logic [IDX_W-1:0] rd_line;
	logic [1:0] rd_word;
	logic rd_valid;
	logic rd_lock;
	logic [TAG_W-1:0] rd_tag;
	logic [31:0] rd_data;
	logic [IDX_W-1:0] wr_line;
	logic [1:0] wr_word;
	logic wr_data_en;
	logic [31:0] wr_data;
	logic wr_tag_en;
	logic [TAG_W-1:0] wr_tag;
	logic wr_lock;
	logic inval_en;
	modport ctrl (output rd_line, rd_word, wr_line, wr_word, wr_data_en, wr_data, wr_tag_en, wr_tag, wr_lock,
		inval_en, input rd_valid, rd_lock, rd_tag, rd_data);
	modport store (input rd_line, rd_word, wr_line, wr_word, wr_data_en, wr_data, wr_tag_en, wr_tag, wr_lock,
		inval_en, output rd_valid, rd_lock, rd_tag, rd_data);
endinterface

// >>> verilog/l1c_way.sv
// One way of the cache: tag, data, valid and lock storage.
`timescale 1ns/1ps
module l1c_way #(
	parameter int LINES = l1c_pkg::DEF_LINES,
	parameter int LINE_WORDS = l1c_pkg::DEF_LINE_WORDS
) (
	input logic clk, // System clock.
	input logic resetn, // Synchronous reset, active low.
	l1c_way_if.store bus // Controller side.
);
	localparam int IDX_W = $clog2(LINES);
	localparam int DW = $clog2(LINES * LINE_WORDS);
	localparam int TAG_W = 30 - $clog2(LINE_WORDS);

	typedef struct packed
	{
		logic [LINES-1:0] valid;
		logic [LINES-1:0] lock;
	} l1c_way_state_t;

	l1c_way_state_t q;
	l1c_way_state_t d;
	logic [TAG_W-1:0] tags [LINES];
	logic [31:0] data [LINES*LINE_WORDS];

	function automatic logic [DW-1:0] widx(input logic [IDX_W-1:0] l, input logic [1:0] w);
		logic [31:0] t;
		t = 32'(l) * 32'(LINE_WORDS) + 32'(w & 2'(LINE_WORDS - 1));
		return t[DW-1:0];
	endfunction

	always_comb
	begin
		d = q;
		if (bus.wr_tag_en)
		begin
			d.valid[bus.wr_line] = 1'b1;
			d.lock[bus.wr_line] = bus.wr_lock;
		end
		if (bus.inval_en)
		begin
			d.valid[bus.wr_line] = 1'b0;
			d.lock[bus.wr_line] = 1'b0; // [RULE14]
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			q <= '0;
		else
			q <= d;
	end

	always_ff @(posedge clk)
	begin
		if (bus.wr_tag_en)
			tags[bus.wr_line] <= bus.wr_tag;
		if (bus.wr_data_en)
			data[widx(bus.wr_line, bus.wr_word)] <= bus.wr_data;
	end

	assign bus.rd_valid = q.valid[bus.rd_line];
	assign bus.rd_lock = q.lock[bus.rd_line];
	assign bus.rd_tag = tags[bus.rd_line];
	assign bus.rd_data = data[widx(bus.rd_line, bus.rd_word)];
endmodule

// >>> verilog/l1c_cache.sv
// Level-one write-through cache controller with line locking and address partitioning.
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] Index and tag from the physical address.
// [RULE2] Direct-mapped: one tag/data pair per index.
// [RULE3] Valid matching tag returns data without memory.
// [RULE4] Instruction lines four words, data lines one.
// [RULE5] Miss refills line; option fetches four words.
// [RULE6] Every cached store also goes to memory.
// [RULE7] Refill overwrites the entry without write-back.
// [RULE8] Sub-word hit merges into cache, sub-word to memory.
// [RULE9] Sub-word miss writes memory only.
// [RULE10] Sub-word stores take one extra cycle.
// [RULE11] Lock enable locks refilled way; other way fills.
// [RULE12] Second lock at a locked index ignored.
// [RULE13] Stores update locked lines; locks block replacement.
// [RULE14] Clearing valid also clears lock.
// [RULE15] Lock enables at status bits 0x00100000/0x00080000.
// [RULE16] Configuration splits cache into two or four partitions.
// [RULE17] Ranges 0x8 and 0x9 use different partitions.
// [RULE18] Uncached loads come from memory, cache untouched.
// [RULE19] Uncached stores skip lookup and leave cache.
// [RULE20] Pipeline stalls during refill or merge cycle.
module l1c_cache #(
	parameter int LINES = l1c_pkg::DEF_LINES,
	parameter int LINE_WORDS = l1c_pkg::DEF_LINE_WORDS,
	parameter bit INSTR_SIDE = 1'b0
) (
	input logic clk, // System clock.
	input logic resetn, // Synchronous reset, active low.
	input logic psel, // APB select.
	input logic penable, // APB enable.
	input logic pwrite, // APB write.
	input logic [11:0] paddr, // APB byte address.
	input logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error for unmapped address.
	input logic [31:0] processor_status_word, // Processor status word carrying the lock enables.
	input logic cpu_req, // Pipeline access request, held until acknowledge.
	input logic cpu_we, // Request is a store.
	input logic [3:0] cpu_be, // Store byte enables.
	input logic [31:0] cpu_wdata, // Store data.
	input logic cpu_uncached, // Access targets an uncached location.
	input logic [31:0] cpu_vaddr, // Program address, used for partition choice only.
	input logic [31:0] cpu_paddr, // Translated physical address.
	output logic cpu_ack, // Access completed.
	output logic cpu_stall, // Pipeline stage held.
	output logic [31:0] cpu_rdata, // Load data.
	output logic mem_req, // Memory request, held until the last acknowledge.
	output logic mem_we, // Memory write.
	output logic mem_burst4, // Read of four consecutive words.
	output logic [3:0] mem_be, // Memory byte enables.
	output logic [31:0] mem_addr, // Memory byte address.
	output logic [31:0] mem_wdata, // Memory write data.
	input logic mem_ack, // Memory word done.
	input logic [31:0] mem_rdata // Memory read data.
);
	localparam int IDX_W = $clog2(LINES);
	localparam int LWL = $clog2(LINE_WORDS);
	localparam int TAG_W = 30 - LWL;
	localparam bit MULTI_WORD = (LINE_WORDS > 1);

	typedef struct packed
	{
		l1c_pkg::l1c_state_t st;
		logic [31:0] vaddr;
		logic [31:0] paddr;
		logic [31:0] wdata;
		logic [3:0] be;
		logic we;
		logic fill;
		logic [1:0] beat;
		logic fill_way;
		logic hit;
		logic victim_tgl;
		logic [31:0] merged;
		logic two_way;
		logic refill4;
		logic [1:0] part;
		logic inval_pend;
		logic [IDX_W-1:0] inval_line;
		logic inval_way;
		logic lock_ign;
		logic cpu_ack;
		logic cpu_stall;
		logic [31:0] cpu_rdata;
		logic mem_req;
		logic mem_we;
		logic mem_burst4;
		logic [3:0] mem_be;
		logic [31:0] mem_addr;
		logic [31:0] mem_wdata;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} l1c_regs_t;

	l1c_regs_t q;
	l1c_regs_t d;

	l1c_way_if #(.IDX_W(IDX_W), .TAG_W(TAG_W)) w0 ();
	l1c_way_if #(.IDX_W(IDX_W), .TAG_W(TAG_W)) w1 ();

	l1c_way #(.LINES(LINES), .LINE_WORDS(LINE_WORDS)) u_way0 (
		.clk(clk),
		.resetn(resetn),
		.bus(w0)
	);

	l1c_way #(.LINES(LINES), .LINE_WORDS(LINE_WORDS)) u_way1 (
		.clk(clk),
		.resetn(resetn),
		.bus(w1)
	);

	// Line index from the physical address; partitioning replaces the top index bits by program address bits.
	function automatic logic [IDX_W-1:0] line_of(input logic [31:0] pa, input logic [31:0] va, input logic [1:0] part);
		logic [IDX_W-1:0] l;
		l = pa[2+LWL +: IDX_W]; // [RULE1] [RULE2]
		if (part == l1c_pkg::PART_TWO)
			l[IDX_W-1] = va[l1c_pkg::PART_VADDR_LO]; // [RULE16] [RULE17]
		else if (part == l1c_pkg::PART_FOUR)
			l[IDX_W-1 -: 2] = va[l1c_pkg::PART_VADDR_LO +: 2]; // [RULE16]
		return l;
	endfunction

	logic [31:0] fill_addr;
	logic [31:0] cmp_addr;
	logic [IDX_W-1:0] rd_line;
	logic [TAG_W-1:0] cmp_tag;
	logic hit0;
	logic hit1;
	logic victim;
	logic sel_lock;
	logic lock_en;
	logic new_lock;
	logic lock_try_ign;
	logic [31:0] hit_data;
	logic [31:0] merged;
	logic data_en;
	logic tag_en;
	logic inval_en;
	logic wsel;
	logic wr_lock;
	logic last_beat;
	logic apb_done;
	logic apb_inval_wr;

	always_comb
	begin
		fill_addr = q.mem_burst4 ? {q.paddr[31:4], q.beat, 2'h0} : q.paddr;
		cmp_addr = (q.st == l1c_pkg::ST_MEMRD) ? fill_addr : q.paddr;
		rd_line = line_of(cmp_addr, q.vaddr, q.part);
		cmp_tag = cmp_addr[31:2+LWL];
		hit0 = w0.rd_valid && (w0.rd_tag == cmp_tag); // [RULE1] [RULE3]
		hit1 = q.two_way && w1.rd_valid && (w1.rd_tag == cmp_tag);
		// A locked way is never chosen while the other can take the line.
		if (!q.two_way)
			victim = 1'b0; // [RULE2]
		else if (hit0)
			victim = 1'b0;
		else if (hit1)
			victim = 1'b1;
		else if (!w0.rd_valid)
			victim = 1'b0;
		else if (!w1.rd_valid)
			victim = 1'b1;
		else if (w0.rd_lock)
			victim = 1'b1; // [RULE11] [RULE13]
		else if (w1.rd_lock)
			victim = 1'b0; // [RULE11] [RULE13]
		else
			victim = q.victim_tgl;
		lock_en = |(processor_status_word & (INSTR_SIDE ? l1c_pkg::PSW_INSTR_LOCK_MASK :
			l1c_pkg::PSW_DATA_LOCK_MASK)); // [RULE15]
		hit_data = hit0 ? w0.rd_data : w1.rd_data;
		for (int i = 0; i < 4; i++)
			merged[8*i +: 8] = q.be[i] ? q.wdata[8*i +: 8] : hit_data[8*i +: 8]; // [RULE8]
		last_beat = !q.mem_burst4 || (q.beat == l1c_pkg::BURST_LAST_BEAT);
		wsel = (q.st == l1c_pkg::ST_MEMRD && MULTI_WORD) || q.st == l1c_pkg::ST_MERGE ? q.fill_way : victim;
		sel_lock = wsel ? w1.rd_lock : w0.rd_lock;
		new_lock = lock_en && q.two_way && !w0.rd_lock && !w1.rd_lock; // [RULE11]
		lock_try_ign = lock_en && q.two_way && (w0.rd_lock || w1.rd_lock) && !sel_lock; // [RULE12]
		apb_done = psel && penable && q.pready;
		apb_inval_wr = apb_done && pwrite && (paddr == l1c_pkg::REG_INVAL);
		data_en = 1'b0;
		tag_en = 1'b0;
		inval_en = 1'b0;
		wr_lock = 1'b0;
		d = q;
		d.cpu_ack = 1'b0;
		d.pready = 1'b0;

		// Register access: one wait cycle, effects at the completing edge.
		if (psel && penable && !q.pready)
		begin
			d.pready = 1'b1;
			d.pslverr = 1'b0;
			d.prdata = 32'h0000_0000;
			case (paddr)
				l1c_pkg::REG_CTRL:
					d.prdata = {28'h000_0000, q.part, q.refill4, q.two_way};
				l1c_pkg::REG_STATUS:
					d.prdata = {30'h0000_0000, q.lock_ign, q.st != l1c_pkg::ST_IDLE};
				l1c_pkg::REG_INVAL:
					d.prdata = 32'h0000_0000;
				default:
					d.pslverr = 1'b1;
			endcase
		end
		if (apb_done && pwrite)
		begin
			if (paddr == l1c_pkg::REG_CTRL)
			begin
				d.two_way = pwdata[l1c_pkg::CTRL_TWO_WAY];
				d.refill4 = pwdata[l1c_pkg::CTRL_REFILL4];
				d.part = pwdata[l1c_pkg::CTRL_PART_LO +: 2]; // [RULE16]
			end
			if (paddr == l1c_pkg::REG_STATUS && pwdata[l1c_pkg::STAT_LOCK_IGN])
				d.lock_ign = 1'b0;
			if (apb_inval_wr)
			begin
				d.inval_pend = 1'b1;
				d.inval_line = pwdata[IDX_W-1:0];
				d.inval_way = pwdata[l1c_pkg::INVAL_WAY_BIT];
			end
		end

		case (q.st)
			l1c_pkg::ST_IDLE:
			begin
				if (q.inval_pend)
				begin
					inval_en = 1'b1; // [RULE14]
					if (!apb_inval_wr)
						d.inval_pend = 1'b0;
				end
				else if (cpu_req && !q.cpu_ack)
				begin
					d.vaddr = cpu_vaddr;
					d.paddr = cpu_paddr;
					d.wdata = cpu_wdata;
					d.be = cpu_we ? cpu_be : 4'hF;
					d.we = cpu_we;
					d.fill = !cpu_uncached;
					d.beat = 2'h0;
					d.cpu_stall = 1'b1; // [RULE20]
					if (cpu_uncached)
					begin
						d.mem_req = 1'b1; // [RULE18] [RULE19]
						d.mem_we = cpu_we;
						d.mem_burst4 = 1'b0;
						d.mem_be = cpu_we ? cpu_be : 4'hF;
						d.mem_addr = cpu_paddr;
						d.mem_wdata = cpu_wdata;
						d.st = cpu_we ? l1c_pkg::ST_MEMWR : l1c_pkg::ST_MEMRD;
					end
					else
						d.st = l1c_pkg::ST_LOOKUP;
				end
			end
			l1c_pkg::ST_LOOKUP:
			begin
				if (!q.we)
				begin
					if (hit0 || hit1)
					begin
						d.cpu_rdata = hit_data; // [RULE3]
						d.cpu_ack = 1'b1;
						d.cpu_stall = 1'b0;
						d.st = l1c_pkg::ST_IDLE;
					end
					else
					begin
						d.fill_way = victim;
						d.mem_req = 1'b1; // [RULE5]
						d.mem_we = 1'b0;
						d.mem_burst4 = MULTI_WORD || q.refill4; // [RULE4] [RULE5]
						d.mem_be = 4'hF;
						d.mem_addr = (MULTI_WORD || q.refill4) ? {q.paddr[31:4], 4'h0} : q.paddr;
						d.st = l1c_pkg::ST_MEMRD;
					end
				end
				else if (q.be == 4'hF)
				begin
					// Full-word store; a miss allocates only where a line is a single word.
					data_en = hit0 || hit1 || !MULTI_WORD; // [RULE13]
					tag_en = !(hit0 || hit1) && !MULTI_WORD;
					d.mem_req = 1'b1; // [RULE6]
					d.mem_we = 1'b1;
					d.mem_burst4 = 1'b0;
					d.mem_be = 4'hF;
					d.mem_addr = q.paddr;
					d.mem_wdata = q.wdata;
					d.st = l1c_pkg::ST_MEMWR;
				end
				else
				begin
					d.hit = hit0 || hit1;
					d.fill_way = victim;
					d.merged = merged;
					d.st = l1c_pkg::ST_MERGE; // [RULE10]
				end
			end
			l1c_pkg::ST_MERGE:
			begin
				data_en = q.hit; // [RULE8] [RULE9] [RULE13]
				d.mem_req = 1'b1; // [RULE6] [RULE8] [RULE9]
				d.mem_we = 1'b1;
				d.mem_burst4 = 1'b0;
				d.mem_be = q.be;
				d.mem_addr = q.paddr;
				d.mem_wdata = q.wdata;
				d.st = l1c_pkg::ST_MEMWR;
			end
			l1c_pkg::ST_MEMWR:
			begin
				if (mem_ack)
				begin
					d.mem_req = 1'b0;
					d.cpu_ack = 1'b1;
					d.cpu_stall = 1'b0;
					d.st = l1c_pkg::ST_IDLE;
				end
			end
			l1c_pkg::ST_MEMRD:
			begin
				if (mem_ack)
				begin
					if (q.fill)
					begin
						data_en = 1'b1; // [RULE7]
						tag_en = !MULTI_WORD || last_beat; // [RULE4] [RULE7]
						wr_lock = sel_lock || new_lock; // [RULE11] [RULE12]
						if (tag_en && lock_try_ign)
							d.lock_ign = 1'b1; // [RULE12]
						if (tag_en)
							d.victim_tgl = !q.victim_tgl;
					end
					if (!q.mem_burst4 || q.beat == q.paddr[3:2])
						d.cpu_rdata = mem_rdata;
					if (last_beat)
					begin
						d.mem_req = 1'b0;
						d.mem_burst4 = 1'b0;
						d.cpu_ack = 1'b1;
						d.cpu_stall = 1'b0; // [RULE20]
						d.st = l1c_pkg::ST_IDLE;
					end
					else
						d.beat = q.beat + 2'h1;
				end
			end
			default:
				d.st = l1c_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			q <= '0;
			q.st <= l1c_pkg::ST_IDLE;
			q.two_way <= l1c_pkg::CTRL_TWO_WAY_RESET;
			q.refill4 <= l1c_pkg::CTRL_REFILL4_RESET;
			q.part <= l1c_pkg::CTRL_PART_RESET;
		end
		else
			q <= d;
	end

	// Both ways share one address; enables pick the way.
	always_comb
	begin
		w0.rd_line = rd_line;
		w1.rd_line = rd_line;
		w0.rd_word = cmp_addr[3:2];
		w1.rd_word = cmp_addr[3:2];
		w0.wr_line = inval_en ? q.inval_line : rd_line;
		w1.wr_line = inval_en ? q.inval_line : rd_line;
		w0.wr_word = cmp_addr[3:2];
		w1.wr_word = cmp_addr[3:2];
		w0.wr_data = (q.st == l1c_pkg::ST_MEMRD) ? mem_rdata : (q.st == l1c_pkg::ST_MERGE ? q.merged : q.wdata);
		w1.wr_data = w0.wr_data;
		w0.wr_tag = cmp_tag;
		w1.wr_tag = cmp_tag;
		w0.wr_lock = wr_lock;
		w1.wr_lock = wr_lock;
		w0.wr_data_en = data_en && !wsel;
		w1.wr_data_en = data_en && wsel;
		w0.wr_tag_en = tag_en && !wsel;
		w1.wr_tag_en = tag_en && wsel;
		w0.inval_en = inval_en && !q.inval_way;
		w1.inval_en = inval_en && q.inval_way;
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign cpu_ack = q.cpu_ack;
	assign cpu_stall = q.cpu_stall;
	assign cpu_rdata = q.cpu_rdata;
	assign mem_req = q.mem_req;
	assign mem_we = q.mem_we;
	assign mem_burst4 = q.mem_burst4;
	assign mem_be = q.mem_be;
	assign mem_addr = q.mem_addr;
	assign mem_wdata = q.mem_wdata;
endmodule

// >>> bench/l1c_mem_model.sv
// Behavioural main memory that answers the cache's single-word and four-word requests.
`timescale 1ns/1ps
module l1c_mem_model (
	input wire logic clk, // Clock.
	input wire logic resetn, // Reset, active low.
	input wire logic slow, // Insert wait cycles.
	input wire logic mem_req, // Request.
	input wire logic mem_we, // Write.
	input wire logic mem_burst4, // Four-word read.
	input wire logic [3:0] mem_be, // Byte enables.
	input wire logic [31:0] mem_addr, // Byte address.
	input wire logic [31:0] mem_wdata, // Write data.
	output logic mem_ack, // Word done.
	output logic [31:0] mem_rdata, // Read data.
	output int n_xfer // Finished transfers.
);
	logic [31:0] mem [0:1023];
	logic [9:0] wa;
	logic [1:0] beat_q;
	logic [1:0] wait_q;
	logic done_q;
	assign wa = mem_addr[11:2] + {8'h0, beat_q};
	initial
	begin
		mem_ack = 1'h0;
		mem_rdata = 32'h0;
		for (int i = 0; i < 1024; i++)
			mem[i] = 32'h5A5A_0000 | (i << 2);
	end
	// Outside an answer the data lines toggle so a stale sample never looks right.
	always @(posedge clk)
	begin
		mem_ack <= 1'h0;
		mem_rdata <= ~mem_rdata;
		if (!resetn || !mem_req)
		begin
			beat_q <= 2'h0;
			wait_q <= {slow, 1'h0};
			done_q <= 1'h0;
			if (!resetn)
				n_xfer <= 0;
		end
		else if (wait_q != 2'h0)
			wait_q <= wait_q - 2'h1;
		else if (!done_q)
		begin
			mem_ack <= 1'h1;
			mem_rdata <= mem[wa];
			for (int b = 0; b < 4; b++)
				if (mem_we && mem_be[b])
					mem[wa][8*b +: 8] <= mem_wdata[8*b +: 8];
			beat_q <= beat_q + 2'h1;
			wait_q <= {1'h0, slow};
			if (!mem_burst4 || beat_q == 2'h3)
			begin
				done_q <= 1'h1;
				n_xfer <= n_xfer + 1;
			end
		end
	end
endmodule

// >>> bench/l1c_cache_chk.sv
// Concurrent checks on the cache's processor and memory ports.
`timescale 1ns/1ps
module l1c_cache_chk (
	input wire logic clk, // Clock.
	input wire logic resetn, // Reset, active low.
	input wire logic cpu_we, // Store.
	input wire logic [3:0] cpu_be, // Byte enables.
	input wire logic cpu_uncached, // Uncached access.
	input wire logic [31:0] cpu_paddr, // Physical address.
	input wire logic cpu_ack, // Access done.
	input wire logic cpu_stall, // Stage held.
	input wire logic mem_req, // Memory request.
	input wire logic mem_we, // Memory write.
	input wire logic mem_burst4, // Four-word read.
	input wire logic [3:0] mem_be, // Memory byte enables.
	input wire logic [31:0] mem_addr, // Memory address.
	input wire logic mem_ack // Memory word done.
);
	logic [2:0] beats_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	always_ff @(posedge clk)
	begin
		beats_q <= (!resetn || !mem_req) ? 3'h0 : beats_q + {2'h0, mem_ack};
	end
	stall_mem_a: assert property (mem_req |-> cpu_stall)
		else $error("memory access while the stage runs");
	ack_stall_a: assert property (cpu_ack |-> $past(cpu_stall))
		else $error("ack without a stalled cycle before it");
	uncached_go_a: assert property ($rose(cpu_stall) && cpu_uncached |-> ##[0:1] mem_req)
		else $error("uncached access did not go straight to memory");
	uncached_addr_a: assert property (mem_req && cpu_uncached |-> mem_addr[31:2] == cpu_paddr[31:2])
		else $error("uncached memory address wrong");
	store_pass_a: assert property (mem_req && mem_we |-> mem_be == cpu_be && mem_addr[31:2] == cpu_paddr[31:2])
		else $error("memory write bytes or address wrong");
	full_store_a: assert property ($rose(cpu_stall) && cpu_we && !cpu_uncached && cpu_be == 4'hF
		|-> !mem_req ##1 mem_req)
		else $error("full-word store timing wrong");
	part_store_a: assert property ($rose(cpu_stall) && cpu_we && !cpu_uncached && cpu_be != 4'hF
		|-> !mem_req [*2] ##1 mem_req)
		else $error("sub-word store lacks its extra cycle");
	burst_align_a: assert property (mem_req && mem_burst4 |-> !mem_we && mem_addr[3:0] == 4'h0)
		else $error("burst read not aligned");
	beat_count_a: assert property ($fell(mem_req) |-> beats_q == ($past(mem_burst4) ? 3'h4 : 3'h1))
		else $error("wrong number of memory beats");
	write_through_a: assert property (cpu_ack && cpu_we |-> $past(mem_ack) && $past(mem_we))
		else $error("store finished without a memory write");
	cover property ($rose(cpu_stall) && cpu_uncached);
	cover property (mem_req && mem_burst4 && mem_ack);
	cover property ($rose(cpu_stall) && cpu_we && cpu_be != 4'hF);
endmodule
bind l1c_cache l1c_cache_chk u_chk (.clk(clk), .resetn(resetn), .cpu_we(cpu_we), .cpu_be(cpu_be),
	.cpu_uncached(cpu_uncached), .cpu_paddr(cpu_paddr), .cpu_ack(cpu_ack), .cpu_stall(cpu_stall),
	.mem_req(mem_req), .mem_we(mem_we), .mem_burst4(mem_burst4), .mem_be(mem_be), .mem_addr(mem_addr),
	.mem_ack(mem_ack));

// >>> bench/tb.sv
// Self-checking bench for the data cache over its APB, processor and memory ports.
`timescale 1ns/1ps
module tb;
	localparam logic [31:0] va8 = 32'h8000_0000;
	localparam logic [31:0] va9 = 32'h9000_0000;
	logic clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, slow = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, psw = 32'h0, cpu_wdata = 32'h0, cpu_vaddr = 32'h0, cpu_paddr = 32'h0;
	logic cpu_req = 1'h0, cpu_we = 1'h0, cpu_uncached = 1'h0;
	logic [3:0] cpu_be = 4'hF;
	logic pready, pslverr, cpu_ack, cpu_stall, mem_req, mem_we, mem_burst4, mem_ack;
	logic [31:0] prdata, cpu_rdata, mem_addr, mem_wdata, mem_rdata, x0;
	logic [3:0] mem_be;
	logic [31:0] sh [0:1023];
	logic [31:0] exp_q [$];
	int n_mismatch = 0, cmp_count = 0, n_xfer, cyc = 0, seed = 92516;
	always #25 clk = ~clk;
	l1c_cache uut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.processor_status_word(psw), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_be(cpu_be),
		.cpu_wdata(cpu_wdata), .cpu_uncached(cpu_uncached), .cpu_vaddr(cpu_vaddr), .cpu_paddr(cpu_paddr),
		.cpu_ack(cpu_ack), .cpu_stall(cpu_stall), .cpu_rdata(cpu_rdata), .mem_req(mem_req), .mem_we(mem_we),
		.mem_burst4(mem_burst4), .mem_be(mem_be), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));
	l1c_mem_model u_mem (.clk(clk), .resetn(resetn), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
		.mem_burst4(mem_burst4), .mem_be(mem_be), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .n_xfer(n_xfer));
	task give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] v, input logic [31:0] e);
		cmp_count++;
		if (v !== e)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, v, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		chk({31'h0, pslverr}, {31'h0, a > 12'h008});
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'h0, a, 32'h0);
	endtask
	// A memory transfer count below zero means the count is not checked.
	task cpu(input logic we, input logic unc, input logic [3:0] be, input logic [31:0] va,
		input logic [11:0] pa, input logic [31:0] d, input int na);
		int n0;
		@(posedge clk);
		n0 = n_xfer;
		cpu_req <= 1'h1;
		cpu_we <= we;
		cpu_uncached <= unc;
		cpu_be <= be;
		cpu_vaddr <= va;
		cpu_paddr <= {20'h0, pa};
		cpu_wdata <= d;
		do @(posedge clk); while (cpu_ack !== 1'h1);
		cpu_req <= 1'h0;
		if (na >= 0)
			chk(n_xfer - n0, na);
	endtask
	task ld(input logic [31:0] va, input logic [11:0] pa, input int na);
		exp_q.push_back(sh[pa[11:2]]);
		cpu(1'h0, 1'h0, 4'hF, va, pa, 32'h0, na);
	endtask
	task st(input logic unc, input logic [3:0] be, input logic [11:0] pa, input logic [31:0] d, input int na);
		for (int b = 0; b < 4; b++)
			if (be[b])
				sh[pa[11:2]][8*b +: 8] = d[8*b +: 8];
		cpu(1'h1, unc, be, va8, pa, d, na);
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cpu_ack === 1'h1 && cpu_we === 1'h0 || pready === 1'h1 && pwrite === 1'h0)
			chk(cpu_ack === 1'h1 ? cpu_rdata : prdata, exp_q.pop_front());
		if (cyc > 30000)
		begin
			n_mismatch++;
			give_verdict;
		end
	end
	initial
	begin
		for (int i = 0; i < 1024; i++)
			sh[i] = 32'h5A5A_0000 | (i << 2);
		repeat (5) @(posedge clk);
		resetn <= 1'h1;
		rd(12'h000, 32'h0);
		rd(12'h004, 32'h0);
		rd(12'h00C, 32'h0);
		ld(va8, 12'h040, 1);
		ld(va8, 12'h040, 0);
		ld(va8, 12'h440, 1);
		ld(va8, 12'h040, 1);
		st(1'h0, 4'h2, 12'h040, 32'h0000_AB00, 1);
		ld(va8, 12'h040, 0);
		st(1'h0, 4'h4, 12'h080, 32'h00CD_0000, 1);
		ld(va8, 12'h080, 1);
		ld(va8, 12'h0C0, 1);
		x0 = sh[48];
		st(1'h1, 4'hF, 12'h0C0, 32'h1234_5678, 1);
		exp_q.push_back(sh[48]);
		cpu(1'h0, 1'h1, 4'hF, va8, 12'h0C0, 32'h0, 1);
		exp_q.push_back(x0);
		cpu(1'h0, 1'h0, 4'hF, va8, 12'h0C0, 32'h0, 0);
		apb(1'h1, 12'h008, 32'h30);
		ld(va8, 12'h0C0, 1);
		apb(1'h1, 12'h000, 32'h2);
		for (int k = 0; k < 4; k++)
			ld(va8, 12'h200 + 4 * k, k == 0);
		apb(1'h1, 12'h000, 32'h4);
		for (int k = 0; k < 4; k++)
			ld(k[0] ? va9 : va8, 12'h300, k < 2);
		apb(1'h1, 12'h000, 32'h8);
		for (int k = 0; k < 8; k++)
			ld({2'h2, k[1:0], 28'h0}, 12'h340, k < 4);
		apb(1'h1, 12'h000, 32'h1);
		psw <= l1c_pkg::PSW_DATA_LOCK_MASK;
		ld(va8, 12'h140, 1);
		psw <= 32'h0;
		ld(va8, 12'h540, 1);
		ld(va8, 12'h940, 1);
		ld(va8, 12'h140, 0);
		psw <= l1c_pkg::PSW_DATA_LOCK_MASK;
		ld(va8, 12'hD40, 1);
		rd(12'h004, 32'h2);
		apb(1'h1, 12'h004, 32'h2);
		rd(12'h004, 32'h0);
		psw <= 32'h0;
		ld(va8, 12'h540, 1);
		ld(va8, 12'h140, 0);
		st(1'h0, 4'hF, 12'h140, $random(seed), 1);
		ld(va8, 12'h140, 0);
		apb(1'h1, 12'h008, 32'h0001_0050);
		ld(va8, 12'h140, 1);
		// A lock left behind by the invalidate would make this new lock attempt count as ignored.
		psw <= l1c_pkg::PSW_DATA_LOCK_MASK;
		ld(va8, 12'h940, 1);
		rd(12'h004, 32'h0);
		psw <= 32'h0;
		apb(1'h1, 12'h000, 32'h0);
		slow <= 1'h1;
		repeat (60)
		begin
			x0 = $random(seed);
			if (x0[0])
				st(1'h0, x0[7:4] == 4'h0 ? 4'hF : x0[7:4], {4'h0, x0[13:8], 2'h0}, $random(seed), -1);
			else
				ld(va8, {4'h0, x0[13:8], 2'h0}, -1);
		end
		give_verdict;
	end
endmodule
